/* verilog/pwr_save_pkg.sv */
// Purpose: shared constants of the power-saving control block
// Assumes: AHB-Lite slave, 32-bit data, word-aligned registers
// Notes:   offsets are byte addresses; bit positions within each register
package pwr_save_pkg;
  localparam int unsigned AddrW = 8;
  localparam logic [7:0] VoltCtrlOff   = 8'h00;
  localparam logic [7:0] ClkCtrl0Off   = 8'h04;
  localparam logic [7:0] ClkCtrl1Off   = 8'h08;
  localparam logic [7:0] OscDetOff     = 8'h0c;
  localparam logic [7:0] HsOscOff      = 8'h10;
  localparam logic [7:0] TmrAModeOff   = 8'h14;
  localparam logic [7:0] TmrBModeOff   = 8'h18;
  localparam logic [7:0] ModStbyOff    = 8'h1c;
  localparam logic [7:0] AdcCtrl1Off   = 8'h20;
  localparam logic [7:0] FlashMode0Off = 8'h24;
  localparam logic [7:0] FlashMode2Off = 8'h28;
  localparam logic [7:0] ModeOff       = 8'h2c;
  localparam logic [7:0] StatusOff     = 8'h30;
  // field positions
  localparam int unsigned IntPwrRedBit   = 0;
  localparam int unsigned Det0EnBit      = 5;
  localparam int unsigned Det1EnBit      = 6;
  localparam int unsigned Det2EnBit      = 7;
  localparam int unsigned WaitPclkStpBit = 2;
  localparam int unsigned LsOscOffBit    = 4;
  localparam int unsigned OscDetSelBit   = 2;
  localparam int unsigned HsOscEnBit     = 0;
  localparam int unsigned CntCutBit      = 7;
  localparam int unsigned TmrCStbyBit    = 3;
  localparam int unsigned TmrDStbyBit    = 2;
  localparam int unsigned AdcStbyBit     = 5;
  localparam int unsigned FlashStopBit   = 3;
  localparam int unsigned LowCurRdBit    = 7;
  localparam int unsigned WaitReqBit     = 0;
  localparam int unsigned StopReqBit     = 1;
  localparam int unsigned RewriteEnBit   = 2;
  localparam int unsigned NumPclk        = 5;
  // reset values: detectors on, oscillators running, converter stopped
  localparam logic [7:0] VoltCtrlRst   = 8'he0;
  localparam logic [7:0] ClkCtrl0Rst   = 8'h00;
  localparam logic [7:0] ClkCtrl1Rst   = 8'h00;
  localparam logic [7:0] OscDetRst     = 8'h04;
  localparam logic [7:0] HsOscRst      = 8'h01;
  localparam logic [7:0] ZeroRst       = 8'h00;
  localparam logic [1:0] HtransNonseq  = 2'b10;
endpackage

/* verilog/periph_clock_gate.sv */
// Purpose: gate the divided peripheral clock enables in wait mode
// Assumes: enables are single-cycle ticks on core_clk
// Notes:   registered output, one cycle behind its inputs
module periph_clock_gate #(
  parameter int unsigned Num = 5
) (
  input  wire logic           core_clk,
  input  wire logic           srst,
  input  wire logic [Num-1:0] tickIn,
  input  wire logic           stopInWait,
  input  wire logic           waitMode,
  output logic [Num-1:0]      tickOut
);
  typedef struct packed {
    logic [Num-1:0] tick;
  } gate_state_t;
  gate_state_t st_q;
  gate_state_t st_d;

  // each tick is suppressed alone so the divider chain keeps its phase
  always_comb begin
    st_d = st_q;
    for (int i = 0; i < Num; i++) begin
      st_d.tick[i] = tickIn[i] & ~(stopInWait & waitMode);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tickOut = st_q.tick;
endmodule // periph_clock_gate

/* verilog/power_saving_control.sv */
// Purpose: power-saving control registers and the controls they drive
// Assumes: one AHB-Lite master, single word transfers, zero wait states
// Notes:   write data lands in the cycle after the data phase edge
// Operation
// - detector-1 enable written 0 disables voltage detection 1
// - detector-2 enable at 0 disables voltage detection 2
// - detector-0 enable at 0 disables detection 0; software decides
// - port direction and output level frozen during wait or stop
// - low-speed oscillator stops when off bit 1 and select bit 0
// - high-speed oscillator stops when its enable bit is 0
// - wait-clock-stop bit 1 halts five peripheral clocks in wait
// - timer A count source cut when its cutoff bit is 1
// - timer B count source cut when its cutoff bit is 1
// - timer C in standby when its standby bit is 1
// - converter standby bit 0 stops A/D and analog current
// - flash stop bit 1 stops flash and refuses flash accesses
// - rewrite disabled: flash powers down in wait or stop
// - low-current read bit 1 in low-speed mode cuts read current
// - timer D in standby when its standby bit is 1
// - internal power reduce bit lowers wait-mode consumption
module power_saving_control
  import pwr_save_pkg::*;
(
  input  wire logic                     core_clk,
  input  wire logic                     srst,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic [31:0]                   hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  input  wire logic [pwr_save_pkg::NumPclk-1:0] pclkTickIn,
  input  wire logic [7:0]               portDirIn,
  input  wire logic [7:0]               portOutIn,
  input  wire logic                     flashReqIn,
  output logic [pwr_save_pkg::NumPclk-1:0] pclkTickOut,
  output logic [7:0]                    portDirOut,
  output logic [7:0]                    portOutOut,
  output logic                          det0Enable,
  output logic                          det1Enable,
  output logic                          det2Enable,
  output logic                          intPwrReduce,
  output logic                          lsOscRun,
  output logic                          hsOscRun,
  output logic                          timerASrcEn,
  output logic                          timerBSrcEn,
  output logic                          timerCStandby,
  output logic                          timerDStandby,
  output logic                          adcActive,
  output logic                          flashPowerOn,
  output logic                          flashAccessOk,
  output logic                          flashLowCurRead,
  output logic                          waitMode,
  output logic                          stopMode
);
  typedef struct packed {
    logic [7:0] voltCtrl;
    logic [7:0] clkCtrl0;
    logic [7:0] clkCtrl1;
    logic [7:0] oscDet;
    logic [7:0] hsOsc;
    logic [7:0] tmrAMode;
    logic [7:0] tmrBMode;
    logic [7:0] modStby;
    logic [7:0] adcCtrl1;
    logic [7:0] flashMode0;
    logic [7:0] flashMode2;
    logic [7:0] mode;
    logic       wrPend;
    logic [7:0] wrAddr;
    logic       rdPend;
    logic [7:0] rdAddr;
    logic [31:0] rdata;
    logic [7:0] portDir;
    logic [7:0] portOut;
  } ctrl_state_t;

  ctrl_state_t st_q;
  ctrl_state_t st_d;
  logic        lowPower;
  logic        addrPhase;
  logic [7:0]  wbyte;

  // address phase accepted only for a selected nonsequential transfer
  assign addrPhase = hsel & hready & (htrans == HtransNonseq);
  assign wbyte     = hwdata[7:0];
  assign lowPower  = st_q.mode[WaitReqBit] | st_q.mode[StopReqBit];

  // read mux for the register at the address-phase address
  function automatic logic [31:0] readReg(input ctrl_state_t s,
                                          input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      VoltCtrlOff:   v = s.voltCtrl;
      ClkCtrl0Off:   v = s.clkCtrl0;
      ClkCtrl1Off:   v = s.clkCtrl1;
      OscDetOff:     v = s.oscDet;
      HsOscOff:      v = s.hsOsc;
      TmrAModeOff:   v = s.tmrAMode;
      TmrBModeOff:   v = s.tmrBMode;
      ModStbyOff:    v = s.modStby;
      AdcCtrl1Off:   v = s.adcCtrl1;
      FlashMode0Off: v = s.flashMode0;
      FlashMode2Off: v = s.flashMode2;
      ModeOff:       v = s.mode;
      StatusOff:     v = {2'b00, flashLowCurRead, flashAccessOk,
                          flashPowerOn, adcActive, hsOscRun, lsOscRun};
      default:       v = 8'h00;
    endcase
    return {24'h000000, v};
  endfunction

  // bus phases, register writes and port hold
  always_comb begin
    st_d = st_q;
    st_d.wrPend = addrPhase & hwrite;
    st_d.rdPend = addrPhase & ~hwrite;
    if (addrPhase) begin
      st_d.wrAddr = haddr[7:0];
      st_d.rdAddr = haddr[7:0];
    end
    if (addrPhase & ~hwrite) begin
      st_d.rdata = readReg(st_q, haddr[7:0]);
    end
    if (st_q.wrPend) begin
      case (st_q.wrAddr)
        VoltCtrlOff:   st_d.voltCtrl   = wbyte;
        ClkCtrl0Off:   st_d.clkCtrl0   = wbyte;
        ClkCtrl1Off:   st_d.clkCtrl1   = wbyte;
        OscDetOff:     st_d.oscDet     = wbyte;
        HsOscOff:      st_d.hsOsc      = wbyte;
        TmrAModeOff:   st_d.tmrAMode   = wbyte;
        TmrBModeOff:   st_d.tmrBMode   = wbyte;
        ModStbyOff:    st_d.modStby    = wbyte;
        AdcCtrl1Off:   st_d.adcCtrl1   = wbyte;
        FlashMode0Off: st_d.flashMode0 = wbyte;
        FlashMode2Off: st_d.flashMode2 = wbyte;
        ModeOff:       st_d.mode       = wbyte;
        default:       st_d.mode       = st_q.mode;
      endcase
    end
    // ports follow the core only while running, otherwise hold
    if (!lowPower) begin
      st_d.portDir = portDirIn;
      st_d.portOut = portOutIn;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q            <= '0;
      st_q.voltCtrl   <= VoltCtrlRst;
      st_q.clkCtrl0   <= ClkCtrl0Rst;
      st_q.clkCtrl1   <= ClkCtrl1Rst;
      st_q.oscDet     <= OscDetRst;
      st_q.hsOsc      <= HsOscRst;
      st_q.tmrAMode   <= ZeroRst;
      st_q.tmrBMode   <= ZeroRst;
      st_q.modStby    <= ZeroRst;
      st_q.adcCtrl1   <= ZeroRst;
      st_q.flashMode0 <= ZeroRst;
      st_q.flashMode2 <= ZeroRst;
      st_q.mode       <= ZeroRst;
    end else begin
      st_q <= st_d;
    end
  end

  // zero-wait slave, always OKAY; unmapped reads return zero
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_q.rdata;

  // control outputs decoded straight from the registered bits; flashAccessOk also gated by flashReqIn
  assign det1Enable   = st_q.voltCtrl[Det1EnBit];
  assign det2Enable   = st_q.voltCtrl[Det2EnBit];
  assign det0Enable   = st_q.voltCtrl[Det0EnBit];
  assign intPwrReduce = st_q.voltCtrl[IntPwrRedBit];
  // stop only when the detect clock no longer needs the low-speed source
  assign lsOscRun = ~(st_q.clkCtrl1[LsOscOffBit] &
                      ~st_q.oscDet[OscDetSelBit]);
  assign hsOscRun      = st_q.hsOsc[HsOscEnBit];
  assign timerASrcEn   = ~st_q.tmrAMode[CntCutBit];
  assign timerBSrcEn   = ~st_q.tmrBMode[CntCutBit];
  assign timerCStandby = st_q.modStby[TmrCStbyBit];
  assign timerDStandby = st_q.modStby[TmrDStbyBit];
  assign adcActive     = st_q.adcCtrl1[AdcStbyBit];
  assign waitMode      = st_q.mode[WaitReqBit];
  assign stopMode      = st_q.mode[StopReqBit];
  // flash power drops on stop bit, or on low power with rewrite off
  assign flashPowerOn = ~st_q.flashMode0[FlashStopBit] &
                        ~(lowPower & ~st_q.mode[RewriteEnBit]);
  assign flashAccessOk = flashPowerOn & flashReqIn;
  // only meaningful while the low-speed source runs the core
  assign flashLowCurRead = st_q.flashMode2[LowCurRdBit] & lsOscRun;
  assign portDirOut = st_q.portDir;
  assign portOutOut = st_q.portOut;

  periph_clock_gate #(
    .Num(NumPclk)
  ) u_pclk_gate (
    .core_clk   (core_clk),
    .srst       (srst),
    .tickIn     (pclkTickIn),
    .stopInWait (st_q.clkCtrl0[WaitPclkStpBit]),
    .waitMode   (st_q.mode[WaitReqBit]),
    .tickOut    (pclkTickOut)
  );

  // a write lands exactly one cycle after its data phase
  write_lands_a: assert property (
    @(posedge core_clk) disable iff (srst)
    st_q.wrPend && st_q.wrAddr == AdcCtrl1Off |=>
      adcActive == $past(hwdata[AdcStbyBit]))
    else $error("converter standby bit not applied");

  // detector 1 switched off by software stops on the next cycle
  det1_off_a: assert property (
    @(posedge core_clk) disable iff (srst)
    st_q.wrPend && st_q.wrAddr == VoltCtrlOff && !hwdata[Det1EnBit]
      |=> !det1Enable)
    else $error("detector 1 still enabled");

  // detector 2 goes off the cycle after its enable bit is written 0
  det2_off_a: assert property (
    @(posedge core_clk) disable iff (srst)
    st_q.wrPend && st_q.wrAddr == VoltCtrlOff && !hwdata[Det2EnBit]
      |=> !det2Enable)
    else $error("detector 2 still enabled");

  // detector 0 may be cut; whether that is safe is software's call
  det0_off_a: assert property (
    @(posedge core_clk) disable iff (srst)
    st_q.wrPend && st_q.wrAddr == VoltCtrlOff && !hwdata[Det0EnBit]
      |=> !det0Enable)
    else $error("detector 0 still enabled");

  // internal power reduction follows its written bit
  int_pwr_a: assert property (
    @(posedge core_clk) disable iff (srst)
    st_q.wrPend && st_q.wrAddr == VoltCtrlOff |=>
      intPwrReduce == $past(hwdata[IntPwrRedBit]))
    else $error("internal power reduce bit not applied");

  // ports must not move once the core sleeps
  ports_held_a: assert property (
    @(posedge core_clk) disable iff (srst)
    lowPower && $past(lowPower) |-> $stable(portDirOut) && $stable(portOutOut))
    else $error("port state changed in low power");

  // the detect clock still needs the low-speed source when selected
  ls_osc_a: assert property (
    @(posedge core_clk) disable iff (srst)
    st_q.clkCtrl1[LsOscOffBit] && st_q.oscDet[OscDetSelBit] |-> lsOscRun)
    else $error("low-speed oscillator stopped while selected");

  // deselecting the detect clock with the off bit set stops the source
  ls_osc_stop_a: assert property (
    @(posedge core_clk) disable iff (srst)
    st_q.wrPend && st_q.wrAddr == OscDetOff && !hwdata[OscDetSelBit] &&
      st_q.clkCtrl1[LsOscOffBit] |=> !lsOscRun)
    else $error("low-speed oscillator still running");

  // high-speed oscillator stops when its enable is written low
  hs_osc_a: assert property (
    @(posedge core_clk) disable iff (srst)
    st_q.wrPend && st_q.wrAddr == HsOscOff && !hwdata[HsOscEnBit]
      |=> !hsOscRun)
    else $error("high-speed oscillator still running");

  // ticks are suppressed once the gate has seen wait for a cycle
  pclk_gate_a: assert property (
    @(posedge core_clk) disable iff (srst)
    st_q.clkCtrl0[WaitPclkStpBit] && waitMode ##1
      st_q.clkCtrl0[WaitPclkStpBit] && waitMode |-> pclkTickOut == '0)
    else $error("peripheral clock ran in wait");

  // timer A source follows the written cutoff bit
  tmr_cut_a: assert property (
    @(posedge core_clk) disable iff (srst)
    st_q.wrPend && st_q.wrAddr == TmrAModeOff |=>
      timerASrcEn == !$past(hwdata[CntCutBit]))
    else $error("timer A source not cut");

  // timer B source follows the written cutoff bit
  tmr_b_cut_a: assert property (
    @(posedge core_clk) disable iff (srst)
    st_q.wrPend && st_q.wrAddr == TmrBModeOff |=>
      timerBSrcEn == !$past(hwdata[CntCutBit]))
    else $error("timer B source not cut");

  // timer C standby follows its written bit
  tmr_c_stby_a: assert property (
    @(posedge core_clk) disable iff (srst)
    st_q.wrPend && st_q.wrAddr == ModStbyOff |=>
      timerCStandby == $past(hwdata[TmrCStbyBit]))
    else $error("timer C standby not applied");

  // timer D standby follows its written bit
  tmr_d_stby_a: assert property (
    @(posedge core_clk) disable iff (srst)
    st_q.wrPend && st_q.wrAddr == ModStbyOff |=>
      timerDStandby == $past(hwdata[TmrDStbyBit]))
    else $error("timer D standby not applied");

  // writing standby stops the converter and its analog current
  adc_stby_a: assert property (
    @(posedge core_clk) disable iff (srst)
    st_q.wrPend && st_q.wrAddr == AdcCtrl1Off && !hwdata[AdcStbyBit]
      |=> !adcActive)
    else $error("converter still active");

  // a stopped flash is neither powered nor accessible
  flash_stop_a: assert property (
    @(posedge core_clk) disable iff (srst)
    st_q.flashMode0[FlashStopBit] |-> !flashAccessOk && !flashPowerOn)
    else $error("flash accessed while stopped");

  // stop mode without rewrite powers the flash down
  flash_auto_a: assert property (
    @(posedge core_clk) disable iff (srst)
    !st_q.mode[RewriteEnBit] && stopMode |-> !flashPowerOn)
    else $error("flash powered in stop mode");

  // wait mode without rewrite powers the flash down as well
  flash_wait_a: assert property (
    @(posedge core_clk) disable iff (srst)
    !st_q.mode[RewriteEnBit] && waitMode |-> !flashPowerOn)
    else $error("flash powered in wait mode");

  // low-current read turns on next cycle while low-speed runs
  low_cur_a: assert property (
    @(posedge core_clk) disable iff (srst)
    st_q.wrPend && st_q.wrAddr == FlashMode2Off && hwdata[LowCurRdBit] &&
      lsOscRun |=> flashLowCurRead)
    else $error("low-current read not enabled");

  // without a write the voltage and standby settings never drift
  setting_hold_a: assert property (
    @(posedge core_clk) disable iff (srst)
    !st_q.wrPend |=> $stable(st_q.voltCtrl) && $stable(st_q.modStby))
    else $error("setting changed without a write");
endmodule // power_saving_control

/* sim/tb_power_saving_control.sv */
// Purpose: self-checking bench for the power-saving control block
// Assumes: zero-wait AHB-Lite slave, controls change the cycle after a write
// Notes:   wait/stop come from the mode register, so modes are software driven
module tb_power_saving_control;
  timeunit 1ns;
  timeprecision 1ps;
  import pwr_save_pkg::*;
  logic        core_clk, srst, hwrite, flashReqIn;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic        hreadyout, hresp;
  wire  logic  hready;
  logic [4:0]  pclkTickIn, pclkTickOut;
  logic [7:0]  portDirIn, portOutIn, portDirOut, portOutOut;
  logic        det0Enable, det1Enable, det2Enable, intPwrReduce, lsOscRun;
  logic        hsOscRun, timerASrcEn, timerBSrcEn, timerCStandby;
  logic        timerDStandby, adcActive, flashPowerOn, flashAccessOk;
  logic        flashLowCurRead, waitMode, stopMode;
  int          failCount, comparisons;

  // single slave on the bus, so its ready is the bus ready
  assign hready = hreadyout;

  power_saving_control dut_u (.core_clk(core_clk), .srst(srst), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pclkTickIn(pclkTickIn),
    .portDirIn(portDirIn), .portOutIn(portOutIn), .flashReqIn(flashReqIn),
    .pclkTickOut(pclkTickOut), .portDirOut(portDirOut),
    .portOutOut(portOutOut), .det0Enable(det0Enable),
    .det1Enable(det1Enable), .det2Enable(det2Enable),
    .intPwrReduce(intPwrReduce), .lsOscRun(lsOscRun), .hsOscRun(hsOscRun),
    .timerASrcEn(timerASrcEn), .timerBSrcEn(timerBSrcEn),
    .timerCStandby(timerCStandby), .timerDStandby(timerDStandby),
    .adcActive(adcActive), .flashPowerOn(flashPowerOn),
    .flashAccessOk(flashAccessOk), .flashLowCurRead(flashLowCurRead),
    .waitMode(waitMode), .stopMode(stopMode));

  // free-running 50 MHz core clock
  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk1(input string nm, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic chk32(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // bounded wait for ready; a hang ends the run as a mismatch
  task automatic wait_ready();
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (hreadyout === 1'b1) break;
    end
    if (n == 20) begin
      failCount++;
      $display("wrong value hready expected 1 seen timeout");
      complete_run();
    end
  endtask

  // one single word transfer: address phase, then data phase
  task automatic xfer(input logic [7:0] a, input logic wr,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge core_clk);
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    htrans <= HtransNonseq;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  // returns at the falling edge after the register has taken the data
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    xfer(a, 1'b1, d, unused);
    @(negedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    xfer(a, 1'b0, 32'h00000000, v);
    chk32("read data", exp, v);
  endtask

  initial begin
    failCount = 0;
    comparisons = 0;
    srst = 1'b1; htrans = 2'b00; hwrite = 1'b0; haddr = 32'h0;
    hwdata = 32'h0; pclkTickIn = 5'h00; portDirIn = 8'h00;
    portOutIn = 8'h00; flashReqIn = 1'b0;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk);
    // reset state of four outputs, VoltCtrl, OscDet, status and an unmapped read
    chk1("det0", 1'b1, det0Enable);
    chk1("hsOsc", 1'b1, hsOscRun);
    chk1("adc", 1'b0, adcActive);
    chk1("hresp", 1'b0, hresp);
    rd(VoltCtrlOff, 32'h000000e0);
    rd(OscDetOff, 32'h00000004);
    rd(StatusOff, 32'h0000000b);
    rd(8'h80, 32'h00000000);
    $display("test reset done");
    // detectors and internal power reduction; upper data bits dropped
    wr(VoltCtrlOff, 32'habcd0001);
    chk1("det1", 1'b0, det1Enable);
    chk1("det2", 1'b0, det2Enable);
    chk1("det0", 1'b0, det0Enable);
    chk1("intPwr", 1'b1, intPwrReduce);
    rd(VoltCtrlOff, 32'h00000001);
    wr(VoltCtrlOff, 32'h00000060);
    chk1("det2", 1'b0, det2Enable);
    chk1("det1", 1'b1, det1Enable);
    $display("test voltage done");
    // low-speed oscillator needs both conditions, then high-speed
    wr(ClkCtrl1Off, 32'h00000010);
    chk1("lsOsc", 1'b1, lsOscRun);
    wr(OscDetOff, 32'h00000000);
    chk1("lsOsc", 1'b0, lsOscRun);
    rd(StatusOff, 32'h0000000a);
    wr(ClkCtrl1Off, 32'h00000000);
    chk1("lsOsc", 1'b1, lsOscRun);
    wr(HsOscOff, 32'h00000000);
    chk1("hsOsc", 1'b0, hsOscRun);
    wr(HsOscOff, 32'h00000001);
    $display("test oscillators done");
    // timer sources, standbys and converter
    wr(TmrAModeOff, 32'h00000080);
    chk1("timerA", 1'b0, timerASrcEn);
    chk1("timerB", 1'b1, timerBSrcEn);
    wr(TmrBModeOff, 32'h00000080);
    chk1("timerB", 1'b0, timerBSrcEn);
    wr(ModStbyOff, 32'h00000008);
    chk1("timerC", 1'b1, timerCStandby);
    chk1("timerD", 1'b0, timerDStandby);
    wr(ModStbyOff, 32'h00000004);
    chk1("timerC", 1'b0, timerCStandby);
    chk1("timerD", 1'b1, timerDStandby);
    wr(AdcCtrl1Off, 32'h00000020);
    chk1("adc", 1'b1, adcActive);
    wr(AdcCtrl1Off, 32'h00000000);
    chk1("adc", 1'b0, adcActive);
    $display("test timers done");
    // flash stop refuses access; low-current read in low-speed mode
    flashReqIn <= 1'b1;
    wr(FlashMode0Off, 32'h00000008);
    chk1("flashPwr", 1'b0, flashPowerOn);
    chk1("flashOk", 1'b0, flashAccessOk);
    wr(FlashMode0Off, 32'h00000000);
    chk1("flashOk", 1'b1, flashAccessOk);
    wr(FlashMode2Off, 32'h00000080);
    chk1("lowCur", 1'b1, flashLowCurRead);
    wr(FlashMode2Off, 32'h00000000);
    chk1("lowCur", 1'b0, flashLowCurRead);
    $display("test flash done");
    // wait and stop: clock gating, port retention, flash power-down
    pclkTickIn <= 5'h1f;
    portDirIn  <= 8'ha5;
    portOutIn  <= 8'h3c;
    wr(ClkCtrl0Off, 32'h00000004);
    wr(ModeOff, 32'h00000001);
    chk1("wait", 1'b1, waitMode);
    chk1("flashPwr", 1'b0, flashPowerOn);
    portDirIn <= 8'h5a;
    repeat (2) @(negedge core_clk);
    chk32("ticks", 32'h0, {27'h0, pclkTickOut});
    chk32("portDir", 32'ha5, {24'h0, portDirOut});
    wr(ModeOff, 32'h00000002);
    chk1("stop", 1'b1, stopMode);
    chk1("flashPwr", 1'b0, flashPowerOn);
    chk32("portOut", 32'h3c, {24'h0, portOutOut});
    wr(ModeOff, 32'h00000005);
    chk1("flashPwr", 1'b1, flashPowerOn);
    wr(ClkCtrl0Off, 32'h00000000);
    @(negedge core_clk);
    chk32("ticks", 32'h1f, {27'h0, pclkTickOut});
    wr(ModeOff, 32'h00000000);
    chk1("flashPwr", 1'b1, flashPowerOn);
    repeat (2) @(negedge core_clk);
    chk32("portDir", 32'h5a, {24'h0, portDirOut});
    rd(TmrAModeOff, 32'h00000080);
    $display("test low power modes done");
    // mid-run reset returns every setting to its reset value
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk);
    chk1("det2", 1'b1, det2Enable);
    chk1("timerA", 1'b1, timerASrcEn);
    chk1("wait", 1'b0, waitMode);
    rd(VoltCtrlOff, 32'h000000e0);
    $display("test second reset done");
    complete_run();
  end
endmodule // tb_power_saving_control
